// file: rtl/rxda_defines.vh
// register map, field positions and fixed codes for the receive demux and lane alignment block
`ifndef RXDA_DEFINES_VH
`define RXDA_DEFINES_VH

// register byte addresses on the 18-bit register port
`define RXDA_ADDR_LANE_ALARM_A0 18'h30020
`define RXDA_ADDR_LANE_ALARM_A1 18'h30030
`define RXDA_ADDR_LANE_ALARM_B0 18'h30120
`define RXDA_ADDR_LANE_ALARM_B1 18'h30130
`define RXDA_ADDR_LINK_STATE_A 18'h30804
`define RXDA_ADDR_ALIGN_STATUS_A 18'h30805
`define RXDA_ADDR_WORD_ALIGN_A 18'h30810
`define RXDA_ADDR_GROUP_MODE_A 18'h30811
`define RXDA_ADDR_PAIR_SYNC_A 18'h30814
`define RXDA_ADDR_MODE_RESYNC_A 18'h30820
`define RXDA_ADDR_LINK_STATE_B 18'h30904
`define RXDA_ADDR_ALIGN_STATUS_B 18'h30905
`define RXDA_ADDR_WORD_ALIGN_B 18'h30910
`define RXDA_ADDR_GROUP_MODE_B 18'h30911
`define RXDA_ADDR_PAIR_SYNC_B 18'h30914
`define RXDA_ADDR_MODE_RESYNC_B 18'h30920
`define RXDA_ADDR_CLOCK_SELECT 18'h30A00
`define RXDA_ADDR_WIDE_RESYNC 18'h30A02
`define RXDA_ADDR_WIDE_SYNC 18'h30A03

// reset value of every writable register
`define RXDA_RST_CTRL 8'h00

// group mode register fields
`define RXDA_GM_MODE_LSB 0
`define RXDA_GM_PROTOCOL_BIT 2
`define RXDA_GM_BYPASS_BIT 3
`define RXDA_GM_DECODE_LSB 4

// mode resync and wide resync register fields
`define RXDA_MR_PAIR_LSB 4
`define RXDA_MR_QUAD_BIT 6
`define RXDA_WR_OCTET_BIT 0

// clock select register fields
`define RXDA_CS_RX_LSB 0
`define RXDA_CS_TX_LSB 2
`define RXDA_CS_SOFT_RESET_BIT 7

// alignment group modes
`define RXDA_MODE_SINGLE 2'h0
`define RXDA_MODE_PAIR 2'h1
`define RXDA_MODE_QUAD 2'h2
`define RXDA_MODE_OCTET 2'h3

// link state codes
`define RXDA_LINK_IDLE 2'h0
`define RXDA_LINK_HUNT 2'h1
`define RXDA_LINK_SYNC 2'h2

// special characters: decoded comma, decoded lane align, raw comma halves
`define RXDA_CHAR_COMMA 8'hBC
`define RXDA_CHAR_ALIGN 8'h7C
`define RXDA_RAW_COMMA_P 7'h1F
`define RXDA_RAW_COMMA_N 7'h60

// words allowed after a resync before the group is declared out of sync
`define RXDA_ALIGN_WINDOW 5'h10

`endif

// file: rtl/rxda_top.v
// receive 1:4 demultiplexer with word and multi-lane alignment, plus its output fifo
`timescale 1ns/1ps
`include "rxda_defines.vh"

// Summary of operation
// - decode enable selects decoded characters per lane
// - bit 8 marks a control character
// - bit 9 carries violation or sync status
// - protocol mode aligns lanes on align character
// - four characters leave together as one word
// - comma starts a fresh four-character word while the lane is not word aligned
// - lanes align single, pair, quad or octet
// - group resync acts on rising bit edge
// - lane resync clears its fifo pointers
// - lock alarm reads one when locked
// - link state reads binary 10 synced
// - aligned and done status; resync clears done
// - word align trigger rising edge realigns
// - raw mode packs consecutive ten-bit groups
// - decoded slot: byte, control flag, bit 9
// - word bits 39, 29, 19 carry status
// - sync reset input, per-lane violation enable

// synchronous fifo; width and depth shape the storage, clear drops all words
module rxda_fifo #(
	parameter WIDTH = 40,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst_n,
	input wire clr,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_reg;
	reg [AW-1:0] rptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage has no reset; only pointers and count matter
	always @(posedge clk)
	begin
		if (push)
			mem[wptr_reg] <= in_data;
	end

	// pointers wrap at depth, which must be a power of two
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else if (clr)
		begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wptr_reg <= wptr_reg + 1'b1;
			if (pop)
				rptr_reg <= rptr_reg + 1'b1;
			count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module rxda_top #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire REF_CLK,
	input wire RST_N,
	input wire ALIGN_SYNC_RESET_N,
	input wire [7:0] RX_LANE_CLOCK,
	input wire [79:0] SERDES_RX_CHAR,
	input wire [7:0] SERDES_RX_CV,
	input wire [7:0] PLL_LOCK_FLAG,
	input wire [7:0] VIOLATION_DETECT_ENABLE,
	input wire [17:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	output wire [319:0] RX_WORD_OUT,
	output wire [7:0] RX_WORD_VALID,
	input wire [7:0] RX_WORD_READY,
	output wire SERDES_SOFT_RESET,
	output wire [1:0] RX_CLOCK_SOURCE_SELECT,
	output wire [1:0] TX_CLOCK_SOURCE_SELECT
);
	// lanes of a group: one lane, its pair, its block of four, or all eight
	function [7:0] grp_mask;
		input [2:0] lane;
		input [1:0] mode;
		begin
			case (mode)
				`RXDA_MODE_SINGLE: grp_mask = 8'h01 << lane;
				`RXDA_MODE_PAIR: grp_mask = 8'h03 << {lane[2:1], 1'b0};
				`RXDA_MODE_QUAD: grp_mask = 8'h0F << {lane[2], 2'b00};
				default: grp_mask = 8'hFF;
			endcase
		end
	endfunction

	reg [1:0] rst_sync_reg;
	wire rst_n;
	reg [7:0] lock_s1_reg;
	reg [7:0] lock_s2_reg;
	reg [7:0] wac_a_reg, wac_b_reg, gm_a_reg, gm_b_reg;
	reg [7:0] mrc_a_reg, mrc_b_reg, clk_sel_reg, wide_rc_reg;
	reg [7:0] wac_a_rise_reg, wac_b_rise_reg, mrc_a_rise_reg, mrc_b_rise_reg;
	reg [7:0] wide_rise_reg;
	reg [7:0] rdata_next;
	wire [7:0] lane_seen, lane_done, lane_oos, lane_walign, lane_ovfl;
	wire [15:0] link_code;
	wire [7:0] wa_rise8, rs_rise8;
	wire [3:0] pair_rise4;
	wire [1:0] quad_rise2;
	wire [15:0] gm16;
	wire [7:0] dec8;

	// reset release through two flops; assertion stays asynchronous
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// lock flags come from the analog side and are synchronised
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_s1_reg <= 8'h00;
			lock_s2_reg <= 8'h00;
		end
		else
		begin
			lock_s1_reg <= PLL_LOCK_FLAG;
			lock_s2_reg <= lock_s1_reg;
		end
	end

	// register writes; word align, mode resync and wide resync writes also yield a one-cycle pulse of bits that rose
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wac_a_reg <= `RXDA_RST_CTRL;
			wac_b_reg <= `RXDA_RST_CTRL;
			gm_a_reg <= `RXDA_RST_CTRL;
			gm_b_reg <= `RXDA_RST_CTRL;
			mrc_a_reg <= `RXDA_RST_CTRL;
			mrc_b_reg <= `RXDA_RST_CTRL;
			clk_sel_reg <= `RXDA_RST_CTRL;
			wide_rc_reg <= `RXDA_RST_CTRL;
			wac_a_rise_reg <= 8'h00;
			wac_b_rise_reg <= 8'h00;
			mrc_a_rise_reg <= 8'h00;
			mrc_b_rise_reg <= 8'h00;
			wide_rise_reg <= 8'h00;
		end
		else
		begin
			wac_a_rise_reg <= 8'h00;
			wac_b_rise_reg <= 8'h00;
			mrc_a_rise_reg <= 8'h00;
			mrc_b_rise_reg <= 8'h00;
			wide_rise_reg <= 8'h00;
			if (REG_WR)
			begin
				case (REG_ADDR)
					`RXDA_ADDR_WORD_ALIGN_A:
					begin
						wac_a_reg <= REG_WDATA;
						wac_a_rise_reg <= REG_WDATA & ~wac_a_reg;
					end
					`RXDA_ADDR_WORD_ALIGN_B:
					begin
						wac_b_reg <= REG_WDATA;
						wac_b_rise_reg <= REG_WDATA & ~wac_b_reg;
					end
					`RXDA_ADDR_MODE_RESYNC_A:
					begin
						mrc_a_reg <= REG_WDATA;
						mrc_a_rise_reg <= REG_WDATA & ~mrc_a_reg;
					end
					`RXDA_ADDR_MODE_RESYNC_B:
					begin
						mrc_b_reg <= REG_WDATA;
						mrc_b_rise_reg <= REG_WDATA & ~mrc_b_reg;
					end
					`RXDA_ADDR_WIDE_RESYNC:
					begin
						wide_rc_reg <= REG_WDATA;
						wide_rise_reg <= REG_WDATA & ~wide_rc_reg;
					end
					`RXDA_ADDR_GROUP_MODE_A: gm_a_reg <= REG_WDATA;
					`RXDA_ADDR_GROUP_MODE_B: gm_b_reg <= REG_WDATA;
					`RXDA_ADDR_CLOCK_SELECT: clk_sel_reg <= REG_WDATA;
					default: ;
				endcase
			end
		end
	end

	// soft reset follows its bit, so software makes the pulse by writing 1 then 0
	assign SERDES_SOFT_RESET = clk_sel_reg[`RXDA_CS_SOFT_RESET_BIT];
	assign RX_CLOCK_SOURCE_SELECT = clk_sel_reg[`RXDA_CS_RX_LSB +: 2];
	assign TX_CLOCK_SOURCE_SELECT = clk_sel_reg[`RXDA_CS_TX_LSB +: 2];

	// per-lane views of the block registers
	assign wa_rise8 = {wac_b_rise_reg[3:0], wac_a_rise_reg[3:0]};
	assign rs_rise8 = {mrc_b_rise_reg[3:0], mrc_a_rise_reg[3:0]};
	assign pair_rise4 = {mrc_b_rise_reg[`RXDA_MR_PAIR_LSB +: 2], mrc_a_rise_reg[`RXDA_MR_PAIR_LSB +: 2]};
	assign quad_rise2 = {mrc_b_rise_reg[`RXDA_MR_QUAD_BIT], mrc_a_rise_reg[`RXDA_MR_QUAD_BIT]};
	assign gm16 = {gm_b_reg, gm_a_reg};
	assign dec8 = {gm_b_reg[`RXDA_GM_DECODE_LSB +: 4], gm_a_reg[`RXDA_GM_DECODE_LSB +: 4]};

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_lane
			localparam [2:0] LN = i;
			wire [1:0] mode = gm16[(i / 4) * 8 + `RXDA_GM_MODE_LSB +: 2];
			wire proto = gm16[(i / 4) * 8 + `RXDA_GM_PROTOCOL_BIT];
			wire bypass = gm16[(i / 4) * 8 + `RXDA_GM_BYPASS_BIT];
			wire dec = dec8[i];
			wire cv_en = VIOLATION_DETECT_ENABLE[i];
			wire [7:0] mask = grp_mask(LN, mode);
			reg clk_s1_reg, clk_s2_reg, clk_s3_reg;
			reg [10:0] chr_s1_reg, chr_s2_reg;
			reg [1:0] slot_reg;
			reg [29:0] acc_reg;
			reg cva_reg, lead_reg, walign_reg, seen_reg, done_reg, oos_reg, ovfl_reg;
			reg [4:0] win_reg;
			reg push_reg;
			reg [39:0] push_data_reg;
			reg grp_rs;
			wire strobe, b9, cv_char, is_comma, is_lsync, start, last, lane_rs, fifo_ready;
			wire [9:0] slot_val;
			reg [39:0] word_next;

			// link clock and character cross into this domain together
			always @(posedge REF_CLK or negedge rst_n)
			begin
				if (!rst_n)
				begin
					clk_s1_reg <= 1'b0;
					clk_s2_reg <= 1'b0;
					clk_s3_reg <= 1'b0;
					chr_s1_reg <= 11'h000;
					chr_s2_reg <= 11'h000;
				end
				else
				begin
					clk_s1_reg <= RX_LANE_CLOCK[i];
					clk_s2_reg <= clk_s1_reg;
					clk_s3_reg <= clk_s2_reg;
					chr_s1_reg <= {SERDES_RX_CV[i], SERDES_RX_CHAR[i*10 +: 10]};
					chr_s2_reg <= chr_s1_reg;
				end
			end
			assign strobe = clk_s2_reg & ~clk_s3_reg;

			// slot layout: raw group, or decoded byte with control flag and bit 9
			assign b9 = bypass & cv_en & chr_s2_reg[10];
			assign slot_val = dec ? {b9, chr_s2_reg[8:0]} : chr_s2_reg[9:0];
			assign cv_char = dec & cv_en & chr_s2_reg[10];
			assign is_comma = dec ? (chr_s2_reg[8] && chr_s2_reg[7:0] == `RXDA_CHAR_COMMA) :
				(chr_s2_reg[6:0] == `RXDA_RAW_COMMA_P || chr_s2_reg[6:0] == `RXDA_RAW_COMMA_N);
			// protocol mode aligns lanes on the align character, which needs decoding
			assign is_lsync = proto ? (dec && chr_s2_reg[8] && chr_s2_reg[7:0] == `RXDA_CHAR_ALIGN) :
				is_comma;
			assign start = strobe & ~walign_reg & is_comma;
			assign last = strobe & ~start & (slot_reg == 2'h3);

			// resync source depends on the group the lane belongs to
			always @*
			begin
				case (mode)
					`RXDA_MODE_PAIR: grp_rs = pair_rise4[LN[2:1]];
					`RXDA_MODE_QUAD: grp_rs = quad_rise2[LN[2]];
					`RXDA_MODE_OCTET: grp_rs = wide_rise_reg[`RXDA_WR_OCTET_BIT];
					default: grp_rs = 1'b0;
				endcase
			end
			assign lane_rs = rs_rise8[i] | grp_rs | ~ALIGN_SYNC_RESET_N;

			// completed word; in aligned decoded mode three bit-9 slots carry status
			always @*
			begin
				word_next = {slot_val, acc_reg};
				if (dec && !bypass)
				begin
					word_next[39] = done_reg;
					word_next[29] = cva_reg | cv_char;
					word_next[19] = |(lane_oos & mask);
				end
			end

			// character packing and word alignment
			always @(posedge REF_CLK or negedge rst_n)
			begin
				if (!rst_n)
				begin
					slot_reg <= 2'h0;
					acc_reg <= 30'h00000000;
					cva_reg <= 1'b0;
					lead_reg <= 1'b0;
					walign_reg <= 1'b0;
					push_reg <= 1'b0;
					push_data_reg <= 40'h0000000000;
				end
				else
				begin
					push_reg <= last;
					if (last)
						push_data_reg <= word_next;
					if (start)
					begin
						acc_reg[9:0] <= slot_val;
						slot_reg <= 2'h1;
						walign_reg <= 1'b1;
						cva_reg <= cv_char;
						lead_reg <= is_lsync;
					end
					else
					begin
						if (strobe)
						begin
							if (slot_reg != 2'h3)
								acc_reg[slot_reg*10 +: 10] <= slot_val;
							slot_reg <= slot_reg + 2'h1;
							cva_reg <= (slot_reg == 2'h0) ? cv_char : (cva_reg | cv_char);
							if (slot_reg == 2'h0)
								lead_reg <= is_lsync;
						end
						// a trigger drops alignment; a comma that starts a word (lane not yet aligned) in the same cycle wins
						if (wa_rise8[i] || !ALIGN_SYNC_RESET_N)
							walign_reg <= 1'b0;
					end
				end
			end

			// multi-lane alignment attempt: done when the group lines up or the window ends
			always @(posedge REF_CLK or negedge rst_n)
			begin
				if (!rst_n)
				begin
					seen_reg <= 1'b0;
					done_reg <= 1'b0;
					oos_reg <= 1'b0;
					win_reg <= 5'h00;
					ovfl_reg <= 1'b0;
				end
				else
				begin
					ovfl_reg <= (ovfl_reg & ~lane_rs) | (push_reg & ~fifo_ready);
					if (lane_rs)
					begin
						seen_reg <= 1'b0;
						done_reg <= 1'b0;
						oos_reg <= 1'b0;
						win_reg <= 5'h00;
					end
					else if (!bypass && !done_reg)
					begin
						if (last && lead_reg)
							seen_reg <= 1'b1;
						if (seen_reg && &(lane_seen | ~mask))
							done_reg <= 1'b1;
						else if (last)
						begin
							win_reg <= win_reg + 5'h01;
							if (win_reg == `RXDA_ALIGN_WINDOW - 5'h01)
							begin
								oos_reg <= 1'b1;
								done_reg <= 1'b1;
							end
						end
					end
				end
			end

			assign lane_seen[i] = seen_reg;
			assign lane_done[i] = done_reg;
			assign lane_oos[i] = oos_reg;
			assign lane_walign[i] = walign_reg;
			assign lane_ovfl[i] = ovfl_reg;
			// protocol mode reports the link state, idle otherwise
			assign link_code[i*2 +: 2] = !proto ? `RXDA_LINK_IDLE :
				(walign_reg ? `RXDA_LINK_SYNC : `RXDA_LINK_HUNT);

			// a full fifo drops the word and raises the overflow flag
			rxda_fifo #(
				.WIDTH(40),
				.DEPTH(FIFO_DEPTH),
				.AW(FIFO_AW)
			) u_fifo (
				.clk(REF_CLK),
				.rst_n(rst_n),
				.clr(lane_rs),
				.in_valid(push_reg),
				.in_ready(fifo_ready),
				.in_data(push_data_reg),
				.out_valid(RX_WORD_VALID[i]),
				.out_ready(RX_WORD_READY[i]),
				.out_data(RX_WORD_OUT[i*40 +: 40])
			);
		end
	endgenerate

	// status read mux; unmapped addresses read zero
	always @*
	begin
		case (REG_ADDR)
			`RXDA_ADDR_LANE_ALARM_A0: rdata_next = {3'h0, lock_s2_reg[1], 3'h0, lock_s2_reg[0]};
			`RXDA_ADDR_LANE_ALARM_A1: rdata_next = {3'h0, lock_s2_reg[3], 3'h0, lock_s2_reg[2]};
			`RXDA_ADDR_LANE_ALARM_B0: rdata_next = {3'h0, lock_s2_reg[5], 3'h0, lock_s2_reg[4]};
			`RXDA_ADDR_LANE_ALARM_B1: rdata_next = {3'h0, lock_s2_reg[7], 3'h0, lock_s2_reg[6]};
			`RXDA_ADDR_LINK_STATE_A: rdata_next = link_code[7:0];
			`RXDA_ADDR_LINK_STATE_B: rdata_next = link_code[15:8];
			`RXDA_ADDR_ALIGN_STATUS_A: rdata_next = {lane_done[3:0], lane_walign[3:0]};
			`RXDA_ADDR_ALIGN_STATUS_B: rdata_next = {lane_done[7:4], lane_walign[7:4]};
			`RXDA_ADDR_PAIR_SYNC_A: rdata_next = {4'h0, |lane_ovfl[3:2], |lane_oos[3:2],
				|lane_ovfl[1:0], |lane_oos[1:0]};
			`RXDA_ADDR_PAIR_SYNC_B: rdata_next = {4'h0, |lane_ovfl[7:6], |lane_oos[7:6],
				|lane_ovfl[5:4], |lane_oos[5:4]};
			`RXDA_ADDR_WIDE_SYNC: rdata_next = {1'b0, &lane_done, |lane_ovfl, |lane_oos,
				|lane_ovfl[7:4], |lane_oos[7:4], |lane_ovfl[3:0], |lane_oos[3:0]};
			`RXDA_ADDR_WORD_ALIGN_A: rdata_next = wac_a_reg;
			`RXDA_ADDR_WORD_ALIGN_B: rdata_next = wac_b_reg;
			`RXDA_ADDR_GROUP_MODE_A: rdata_next = gm_a_reg;
			`RXDA_ADDR_GROUP_MODE_B: rdata_next = gm_b_reg;
			`RXDA_ADDR_MODE_RESYNC_A: rdata_next = mrc_a_reg;
			`RXDA_ADDR_MODE_RESYNC_B: rdata_next = mrc_b_reg;
			`RXDA_ADDR_CLOCK_SELECT: rdata_next = clk_sel_reg;
			`RXDA_ADDR_WIDE_RESYNC: rdata_next = wide_rc_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// read data is registered, one cycle after the read strobe, held until the next read
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
			REG_RDATA <= rdata_next;
	end
endmodule

// file: testbench/rxda_checker_props.sv
// concurrent checks on the ports of the receive demux and alignment block
`timescale 1ns/1ps
`include "rxda_defines.vh"
module rxda_checker #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire REF_CLK,
	input wire RST_N,
	input wire ALIGN_SYNC_RESET_N,
	input wire [7:0] PLL_LOCK_FLAG,
	input wire [17:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire [319:0] RX_WORD_OUT,
	input wire [7:0] RX_WORD_VALID,
	input wire [7:0] RX_WORD_READY,
	input wire SERDES_SOFT_RESET,
	input wire [1:0] RX_CLOCK_SOURCE_SELECT,
	input wire [1:0] TX_CLOCK_SOURCE_SELECT
);
	reg [3:0] up_reg;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// edges since reset release; the internal reset copy lags by two flops
	always @(posedge REF_CLK or negedge RST_N)
		if (!RST_N)
			up_reg <= 4'h0;
		else if (up_reg != 4'hF)
			up_reg <= up_reg + 4'h1;
	property p_soft_reset;
		up_reg > 4'h3 && REG_WR && REG_ADDR == `RXDA_ADDR_CLOCK_SELECT
		|=> SERDES_SOFT_RESET == $past(REG_WDATA[7]);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset bit wrong");
	property p_clock_sel;
		up_reg > 4'h3 && REG_WR && REG_ADDR == `RXDA_ADDR_CLOCK_SELECT
		|=> {TX_CLOCK_SOURCE_SELECT, RX_CLOCK_SOURCE_SELECT} == $past(REG_WDATA[3:0]);
	endproperty
	a_clock_sel: assert property (p_clock_sel) else $error("clock selects wrong");
	property p_clock_hold;
		!(REG_WR && REG_ADDR == `RXDA_ADDR_CLOCK_SELECT)
		|=> $stable({SERDES_SOFT_RESET, TX_CLOCK_SOURCE_SELECT, RX_CLOCK_SOURCE_SELECT});
	endproperty
	a_clock_hold: assert property (p_clock_hold) else $error("clock selects moved");
	// a stalled head word stays put unless a write or sync reset may clear the buffer
	property p_word_hold;
		up_reg > 4'h3 && RX_WORD_VALID[0] && !RX_WORD_READY[0] && ALIGN_SYNC_RESET_N
		&& $past(ALIGN_SYNC_RESET_N) && !REG_WR && !$past(REG_WR)
		|=> RX_WORD_VALID[0] && $stable(RX_WORD_OUT[39:0]);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("stalled word lost");
	property p_sync_clear;
		!ALIGN_SYNC_RESET_N [*3] |-> RX_WORD_VALID == 8'h00;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("words under sync reset");
	property p_done_clear;
		!ALIGN_SYNC_RESET_N [*3] ##0 (REG_RD && REG_ADDR == `RXDA_ADDR_ALIGN_STATUS_A)
		|=> REG_RDATA == 8'h00;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("status kept in resync");
	property p_lock_read;
		up_reg == 4'hF && REG_RD && REG_ADDR == `RXDA_ADDR_LANE_ALARM_A0
		&& $stable(PLL_LOCK_FLAG) && PLL_LOCK_FLAG == $past(PLL_LOCK_FLAG, 2)
		&& PLL_LOCK_FLAG == $past(PLL_LOCK_FLAG, 3)
		|=> REG_RDATA == {3'h0, $past(PLL_LOCK_FLAG[1]), 3'h0, $past(PLL_LOCK_FLAG[0])};
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock alarm wrong");
	property p_mode_back;
		up_reg > 4'h3 && REG_WR && REG_ADDR == `RXDA_ADDR_GROUP_MODE_A ##1 !REG_WR
		##1 (REG_RD && !REG_WR && REG_ADDR == `RXDA_ADDR_GROUP_MODE_A)
		|=> REG_RDATA == $past(REG_WDATA, 3);
	endproperty
	a_mode_back: assert property (p_mode_back) else $error("group mode readback wrong");
endmodule
bind rxda_top rxda_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk_i (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .ALIGN_SYNC_RESET_N(ALIGN_SYNC_RESET_N),
	.PLL_LOCK_FLAG(PLL_LOCK_FLAG), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_WORD_OUT(RX_WORD_OUT),
	.RX_WORD_VALID(RX_WORD_VALID), .RX_WORD_READY(RX_WORD_READY),
	.SERDES_SOFT_RESET(SERDES_SOFT_RESET), .RX_CLOCK_SOURCE_SELECT(RX_CLOCK_SOURCE_SELECT),
	.TX_CLOCK_SOURCE_SELECT(TX_CLOCK_SOURCE_SELECT));

// file: testbench/rxda_user_sink.sv
// user-side word sink: pops lane words promptly, with random stalls, or not at all
`timescale 1ns/1ps
module rxda_user_sink (
	input wire clk,
	input wire [1:0] mode,
	input wire valid,
	input wire [39:0] word,
	output reg ready
);
	reg [39:0] got [$];
	initial ready = 1'b0;
	// a word is taken only on an edge with both high; mode 2 stops so the buffer fills
	always @(posedge clk)
	begin
		if (ready && valid)
			got.push_back(word);
		ready <= #1 (mode == 2'h0) || (mode == 2'h1 && $urandom % 3 != 0);
	end
endmodule

// file: testbench/rx_demux_lane_alignment_tb_top.sv
// self-checking bench for the receive demux and lane alignment block
`timescale 1ns/1ps
`include "rxda_defines.vh"
module rx_demux_lane_alignment_tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg sync_n = 1'b1;
	reg lclk = 1'b0;
	reg lrun = 1'b1;
	reg [79:0] chr = 80'h0;
	reg [7:0] cv = 8'h00;
	reg [7:0] lock = 8'h00;
	reg [7:0] cven = 8'hFF;
	reg [17:0] addr = 18'h0;
	reg [7:0] wdat = 8'h00;
	reg wr_en = 1'b0;
	reg rd_en = 1'b0;
	reg [1:0] smode = 2'h0;
	wire [7:0] rdata;
	wire [319:0] words;
	wire [7:0] valid;
	wire ready0;
	wire srst;
	wire [1:0] rsel;
	wire [1:0] tsel;
	integer mismatches = 0;
	integer checked = 0;
	integer i;
	integer b;
	integer n;
	reg [7:0] rv;
	reg [7:0] d, d0, d1;
	reg [17:0] a;
	reg [39:0] w1, w2, wa, wb, ea, m;
	localparam [179:0] RWA = {`RXDA_ADDR_CLOCK_SELECT, `RXDA_ADDR_WORD_ALIGN_A,
		`RXDA_ADDR_GROUP_MODE_A, `RXDA_ADDR_MODE_RESYNC_A, `RXDA_ADDR_WORD_ALIGN_B,
		`RXDA_ADDR_GROUP_MODE_B, `RXDA_ADDR_MODE_RESYNC_B, `RXDA_ADDR_WIDE_RESYNC,
		`RXDA_ADDR_WORD_ALIGN_A, `RXDA_ADDR_GROUP_MODE_A};
	rxda_top uut (.REF_CLK(clk), .RST_N(rst_n), .ALIGN_SYNC_RESET_N(sync_n),
		.RX_LANE_CLOCK({8{lclk}}), .SERDES_RX_CHAR(chr), .SERDES_RX_CV(cv),
		.PLL_LOCK_FLAG(lock), .VIOLATION_DETECT_ENABLE(cven), .REG_ADDR(addr),
		.REG_WDATA(wdat), .REG_WR(wr_en), .REG_RD(rd_en), .REG_RDATA(rdata),
		.RX_WORD_OUT(words), .RX_WORD_VALID(valid), .RX_WORD_READY({7'h7F, ready0}),
		.SERDES_SOFT_RESET(srst), .RX_CLOCK_SOURCE_SELECT(rsel), .TX_CLOCK_SOURCE_SELECT(tsel));
	rxda_user_sink sink (.clk(clk), .mode(smode), .valid(valid[0]), .word(words[39:0]),
		.ready(ready0));
	always #2.5 clk = ~clk;
	// link clock is free running but can be parked to freeze the lane
	initial
	begin
		#2.3;
		forever
		begin
			#32;
			if (lrun)
				lclk = ~lclk;
		end
	end
	task chk(input [39:0] g, input [39:0] e);
	begin
		checked = checked + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	end
	endtask
	task report_and_stop;
	begin
		$display("counts: checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task wr(input [17:0] ad, input [7:0] dt);
	begin
		@(posedge clk);
		#1 addr = ad;
		wdat = dt;
		wr_en = 1'b1;
		@(posedge clk);
		#1 wr_en = 1'b0;
	end
	endtask
	// read data lands one edge after the strobe edge
	task rd(input [17:0] ad);
	begin
		@(posedge clk);
		#1 addr = ad;
		rd_en = 1'b1;
		@(posedge clk);
		#1 rd_en = 1'b0;
		@(posedge clk);
		#1 rv = rdata;
	end
	endtask
	// characters change mid link period so each lane clock rise sees a settled value
	task send(input [39:0] w, input [3:0] v);
		integer k;
	begin
		for (k = 0; k < 4; k = k + 1)
		begin
			@(negedge lclk);
			@(posedge clk);
			#1 chr = {8{w[k*10 +: 10]}};
			cv = {8{v[k]}};
		end
	end
	endtask
	// locate the word led by the marker and the one after it; junk words around are dropped
	task find(input [9:0] c0, input [9:0] mk);
		integer j;
		integer t;
	begin
		j = -1;
		for (t = 0; t < 3000 && j < 0; t = t + 1)
		begin
			@(posedge clk);
			foreach (sink.got[q])
				if (j < 0 && (sink.got[q][9:0] & mk) == c0 && q + 1 < sink.got.size())
					j = q;
		end
		if (j < 0)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: aligned word never arrived", $time);
			report_and_stop;
		end
		w1 = sink.got[j];
		w2 = sink.got[j + 1];
		sink.got.delete();
	end
	endtask
	// random characters kept clear of the raw comma patterns
	function [9:0] rc(input integer z);
		rc = ($urandom & 10'h39F) | 10'h020;
	endfunction
	initial
	begin
		rv = $urandom(33613);
		lock = $urandom;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 10; i = i + 1)
		begin
			a = RWA[i*18 +: 18];
			rd(a);
			// group mode and word align of block a come round a second time
			chk(rv, (i == 7) ? d0 : ((i == 8) ? d1 : 8'h00));
			d = $urandom;
			if (i == 0)
				d0 = d;
			if (i == 1)
				d1 = d;
			if (i == 9)
				d[7] = 1'b0;
			wr(a, d);
			rd(a);
			chk(rv, d);
		end
		chk({tsel, rsel}, d[3:0]);
		wr(`RXDA_ADDR_CLOCK_SELECT, 8'h80);
		chk(srst, 1'b1);
		wr(`RXDA_ADDR_CLOCK_SELECT, 8'h00);
		chk(srst, 1'b0);
		wr(`RXDA_ADDR_LANE_ALARM_A0, 8'hFF);
		rd(`RXDA_ADDR_LANE_ALARM_A0);
		chk(rv, {3'h0, lock[1], 3'h0, lock[0]});
		rd(18'h30001);
		chk(rv, 8'h00);
		$display("test registers done");
		wr(`RXDA_ADDR_GROUP_MODE_A, 8'h08);
		wa = {rc(0), rc(0), rc(0), 10'h09F};
		wb = {rc(0), rc(0), rc(0), rc(0)};
		send(wa, 4'h0);
		send(wb, 4'h0);
		send(40'h0, 4'h0);
		find(10'h09F, 10'h3FF);
		chk(w1, wa);
		chk(w2, wb);
		$display("test raw packing done");
		smode = 2'h1;
		for (b = 0; b < 3; b = b + 1)
		begin
			cven[0] = (b != 2);
			wr(`RXDA_ADDR_GROUP_MODE_A, b ? 8'hF8 : 8'hF0);
			// the lane is still aligned from the last test; drop it so the comma leads
			wr(`RXDA_ADDR_WORD_ALIGN_A, 8'h00);
			wr(`RXDA_ADDR_WORD_ALIGN_A, 8'h01);
			wr(`RXDA_ADDR_MODE_RESYNC_A, 8'h00);
			wr(`RXDA_ADDR_MODE_RESYNC_A, 8'h01);
			wa = {2'b00, rc(0), 2'b00, rc(0), 2'b00, rc(0), 10'h1BC};
			wa[39:10] = wa[39:10] & 30'h0FF3FCFF;
			wb = {10'h0, 2'b00, rc(0), 10'h0, 2'b00, rc(0)} & 40'h00FF000FF;
			send(wa, 4'b0100);
			send(wb, 4'h0);
			send(40'h0, 4'h0);
			find(10'h1BC, 10'h1FF);
			m = {40{1'b1}};
			ea = wa;
			ea[29] = (b != 2);
			chk(w1 & m, ea & m);
			wb[39] = (b == 0);
			m[39] = 1'b1;
			chk(w2 & m, wb & m);
			if (b == 0)
			begin
				rd(`RXDA_ADDR_ALIGN_STATUS_A);
				chk(rv & 8'h11, 8'h11);
				chk(w2[39] & ~w2[19], 1'b1);
			end
		end
		$display("test decoded words done");
		wr(`RXDA_ADDR_GROUP_MODE_A, 8'hF4);
		wr(`RXDA_ADDR_WORD_ALIGN_A, 8'h00);
		wr(`RXDA_ADDR_WORD_ALIGN_A, 8'h01);
		wr(`RXDA_ADDR_MODE_RESYNC_A, 8'h00);
		wr(`RXDA_ADDR_MODE_RESYNC_A, 8'h01);
		// no align character comes, so the attempt window runs out and flags out of sync
		repeat (1000) @(posedge clk);
		rd(`RXDA_ADDR_PAIR_SYNC_A);
		chk(rv[0], 1'b1);
		if (rv[0])
		begin
			wr(`RXDA_ADDR_MODE_RESYNC_A, 8'h00);
			wr(`RXDA_ADDR_MODE_RESYNC_A, 8'h01);
		end
		rd(`RXDA_ADDR_ALIGN_STATUS_A);
		chk(rv[4], 1'b0);
		send({30'h0, 10'h1BC}, 4'h0);
		send({30'h0, 10'h17C}, 4'h0);
		send(40'h0, 4'h0);
		find(10'h17C, 10'h1FF);
		rd(`RXDA_ADDR_ALIGN_STATUS_A);
		chk(rv[4], 1'b1);
		rd(`RXDA_ADDR_LINK_STATE_A);
		chk(rv[1:0], 2'b10);
		$display("test protocol alignment done");
		sync_n = 1'b0;
		repeat (3) @(posedge clk);
		rd(`RXDA_ADDR_ALIGN_STATUS_A);
		chk(rv, 8'h00);
		chk(valid, 8'h00);
		sync_n = 1'b1;
		$display("test sync reset done");
		smode = 2'h2;
		repeat (1200) @(posedge clk);
		#1 lrun = 1'b0;
		repeat (20) @(posedge clk);
		#1 chk(valid[0], 1'b1);
		n = sink.got.size();
		smode = 2'h0;
		repeat (40) @(posedge clk);
		#1 chk(sink.got.size() - n, 16);
		chk(valid[0], 1'b0);
		$display("test buffer fill done");
		report_and_stop;
	end
endmodule
